/* lrit_core.sv */
`timescale 1ns/1ps
module lrit_core #(
    parameter int P_CONV_MIN_CYC = lrit_pkg::CONV_MIN_CYC,
    parameter int P_CONV_MAX_CYC = lrit_pkg::CONV_MAX_CYC,
    parameter int P_TIMEO_CYC = lrit_pkg::TIMEO_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_mode_wr,
    input wire logic [1:0] i_mode_val,
    input wire logic i_range_wr,
    input wire logic [3:0] i_range_val,
    input wire logic [3:0] i_conv_time,
    input wire logic i_threshold_channel_select,
    input wire logic [lrit_pkg::CODE_W-1:0] i_thr_low,
    input wire logic [lrit_pkg::CODE_W-1:0] i_thr_high,
    input wire logic [1:0] i_fault_count,
    input wire logic [lrit_pkg::CODE_W-1:0] i_ch0_code,
    input wire logic [lrit_pkg::CODE_W-1:0] i_ch1_code,
    input wire logic i_scl,
    output logic [1:0] o_mode,
    output logic [3:0] o_range_cfg,
    output logic o_conv_busy,
    output logic [3:0] o_conv_range,
    output logic o_result_valid,
    output lrit_pkg::lrit_result_s o_result,
    output logic o_flag_low,
    output logic o_flag_high,
    output logic o_int_o,
    output logic o_int_oe_n,
    output logic o_bus_sm_rst
);

    lrit_pkg::lrit_state_e state_q;
    logic [1:0] mode_q;
    logic [3:0] range_cfg_q;
    logic [3:0] range_auto_q;
    logic [3:0] range_cur_q;
    logic [lrit_pkg::TMR_W-1:0] tmr_q;
    logic [lrit_pkg::TMR_W-1:0] conv_len;
    logic trig_q;
    logic start;
    logic done;
    logic auto_sel;
    lrit_pkg::lrit_result_s res_q;
    logic [lrit_pkg::CRC_W-1:0] crc_d;
    logic [lrit_pkg::CODE_W-1:0] sel_code;
    logic below;
    logic above;
    logic [2:0] run_q;
    logic [2:0] run_d;
    logic flag_low_q;
    logic flag_high_q;
    logic valid_q;
    logic scl_m_q;
    logic scl_s_q;
    logic [lrit_pkg::TMR_W-1:0] low_cnt_q;
    logic bus_rst_q;

    assign auto_sel = (range_cfg_q == lrit_pkg::RANGE_AUTO);
    assign done = (state_q == lrit_pkg::ST_CONV) && (tmr_q == '0);

    // Conversion length: doubling steps from the shortest, last is longest.
    always_comb begin
        if (i_conv_time >= lrit_pkg::CONV_SEL_LAST) begin
            conv_len = lrit_pkg::TMR_W'(P_CONV_MAX_CYC - 1);
        end else begin
            conv_len = lrit_pkg::TMR_W'((P_CONV_MIN_CYC << i_conv_time) - 1);
        end
    end

    // Mode register; a written one-shot is consumed by its measurement.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            mode_q <= lrit_pkg::MODE_RST;
        end else if (i_mode_wr) begin
            mode_q <= i_mode_val;
        end else if (done && mode_q != lrit_pkg::MODE_CONT) begin
            mode_q <= lrit_pkg::MODE_OFF;
        end
    end

    // One-shot trigger; writes while converting are dropped, not queued.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            trig_q <= 1'b0;
        end else if (i_mode_wr && state_q == lrit_pkg::ST_OFF) begin
            trig_q <= (i_mode_val == lrit_pkg::MODE_ONE_FORCE)
                || (i_mode_val == lrit_pkg::MODE_ONE_REG);
        end else begin
            trig_q <= 1'b0;
        end
    end

    assign start = (state_q == lrit_pkg::ST_OFF)
        && (trig_q || (mode_q == lrit_pkg::MODE_CONT && !i_mode_wr));

    // Range configuration register, automatic after reset.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            range_cfg_q <= lrit_pkg::RANGE_RST;
        end else if (i_range_wr) begin
            range_cfg_q <= i_range_val;
        end
    end

    // Automatic range follows light on every result; forced one-shot
    // restarts it from the widest range and ignores history.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            range_auto_q <= lrit_pkg::RANGE_MAX;
        end else if (trig_q && mode_q == lrit_pkg::MODE_ONE_FORCE) begin
            range_auto_q <= lrit_pkg::RANGE_MAX;
        end else if (done) begin
            if (sel_code[lrit_pkg::CODE_W-1 -: 2] == 2'h3
                && range_cur_q < lrit_pkg::RANGE_MAX) begin
                range_auto_q <= range_cur_q + 4'h1;
            end else if (sel_code[lrit_pkg::CODE_W-1 -: 3] == 3'h0
                && range_cur_q != 4'h0) begin
                range_auto_q <= range_cur_q - 4'h1;
            end else begin
                range_auto_q <= range_cur_q;
            end
        end
    end

    // Sequencer and conversion timer.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            state_q <= lrit_pkg::ST_OFF;
            tmr_q <= '0;
            range_cur_q <= lrit_pkg::RANGE_MAX;
        end else begin
            case (state_q)
                lrit_pkg::ST_OFF: begin
                    if (start) begin
                        state_q <= lrit_pkg::ST_CONV;
                        tmr_q <= conv_len;
                        if (!auto_sel) begin
                            range_cur_q <= (range_cfg_q > lrit_pkg::RANGE_MAX)
                                ? lrit_pkg::RANGE_MAX : range_cfg_q;
                        end else if (mode_q == lrit_pkg::MODE_ONE_FORCE) begin
                            range_cur_q <= lrit_pkg::RANGE_MAX;
                        end else begin
                            range_cur_q <= range_auto_q;
                        end
                    end
                end
                lrit_pkg::ST_CONV: begin
                    if (done) begin
                        state_q <= lrit_pkg::ST_DONE;
                    end else begin
                        tmr_q <= tmr_q - 1'b1;
                    end
                end
                lrit_pkg::ST_DONE: begin
                    state_q <= lrit_pkg::ST_OFF;
                end
                default: begin
                    state_q <= lrit_pkg::ST_OFF;
                end
            endcase
        end
    end

    // Threshold compare on the selected channel.
    assign sel_code = i_threshold_channel_select
        ? i_ch1_code : i_ch0_code;
    assign below = (sel_code < i_thr_low);
    assign above = (sel_code > i_thr_high);
    assign run_d = (run_q == 3'h7) ? run_q : run_q + 3'h1;

    lrit_crc #(
        .DATA_W(lrit_pkg::CRC_DATA_W)
    ) u_crc (
        .i_data({i_ch0_code, i_ch1_code, range_cur_q,
            res_q.count + 4'h1}),
        .o_crc(crc_d)
    );

    // Whole record loads in one edge so a burst never mixes samples.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            res_q <= '0;
            valid_q <= 1'b0;
        end else begin
            valid_q <= done;
            if (done) begin
                res_q.ch0 <= i_ch0_code;
                res_q.ch1 <= i_ch1_code;
                res_q.range <= range_cur_q;
                res_q.count <= res_q.count + 4'h1;
                res_q.crc <= crc_d;
            end
        end
    end

    // Consecutive fault run; flags rise only once the run is long enough.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            run_q <= '0;
            flag_low_q <= 1'b0;
            flag_high_q <= 1'b0;
        end else if (done) begin
            if (below || above) begin
                run_q <= run_d;
                if (run_d >= {1'b0, i_fault_count} + 3'h1) begin
                    flag_low_q <= below;
                    flag_high_q <= above;
                end
            end else begin
                run_q <= '0;
                flag_low_q <= 1'b0;
                flag_high_q <= 1'b0;
            end
        end
    end

    // Clock line watchdog; the pin passes two flops first.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            low_cnt_q <= '0;
            bus_rst_q <= 1'b0;
        end else begin
            scl_m_q <= i_scl;
            scl_s_q <= scl_m_q;
            bus_rst_q <= 1'b0;
            if (scl_s_q) begin
                low_cnt_q <= '0;
            end else if (low_cnt_q != lrit_pkg::TMR_W'(P_TIMEO_CYC)) begin
                low_cnt_q <= low_cnt_q + 1'b1;
                if (low_cnt_q == lrit_pkg::TMR_W'(P_TIMEO_CYC - 1)) begin
                    bus_rst_q <= 1'b1;
                end
            end
        end
    end

    assign o_mode = mode_q;
    assign o_range_cfg = range_cfg_q;
    assign o_conv_busy = (state_q == lrit_pkg::ST_CONV);
    assign o_conv_range = range_cur_q;
    assign o_result_valid = valid_q;
    assign o_result = res_q;
    assign o_flag_low = flag_low_q;
    assign o_flag_high = flag_high_q;
    // Open drain: pull the line low while either flag stands.
    assign o_int_o = 1'b0;
    assign o_int_oe_n = !(flag_low_q || flag_high_q);
    assign o_bus_sm_rst = bus_rst_q;

    sequence s_done_oneshot;
        done && (mode_q != lrit_pkg::MODE_CONT) && !i_mode_wr;
    endsequence

    sequence s_busy_write;
        o_conv_busy && !done && i_mode_wr;
    endsequence

    AST_COUNT_STEP: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        done |=> res_q.count == 4'($past(res_q.count) + 4'h1))
        else $error("Sample count did not step by one.");
    AST_VALID_ONE: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        done |=> o_result_valid ##1 !o_result_valid)
        else $error("Result valid not a single pulse after done.");
    AST_CRC_MATCH: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        done |=> res_q.crc == $past(crc_d))
        else $error("Check field not taken with the record.");
    AST_RECORD_HOLD: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        !done |=> $stable(res_q))
        else $error("Record changed without a measurement.");
    AST_ONESHOT_CLR: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        s_done_oneshot |=> mode_q == lrit_pkg::MODE_OFF)
        else $error("One-shot mode not cleared after measurement.");
    AST_BUSY_IGNORE: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        s_busy_write |=> o_conv_busy && !trig_q)
        else $error("Trigger during conversion was not ignored.");
    AST_SHUTDOWN: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        (mode_q == lrit_pkg::MODE_OFF && !trig_q
            && state_q == lrit_pkg::ST_OFF) |=> !o_conv_busy)
        else $error("Conversion started in shutdown.");
    AST_FLAG_RUN: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        $rose(flag_low_q || flag_high_q)
            |-> run_q >= {1'b0, $past(i_fault_count)} + 3'h1)
        else $error("Flag set before the fault run was reached.");
    AST_TIMEOUT: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        o_bus_sm_rst |-> !$past(scl_s_q) && low_cnt_q ==
            lrit_pkg::TMR_W'(P_TIMEO_CYC))
        else $error("Bus reset without full low time.");

endmodule : lrit_core

/* lrit_pkg.sv */
// Behaviour
// - Count each successful measurement in the output.
// - Four-bit count, zero at power-up, wraps.
// - Check field refreshed with every measurement.
// - Threshold watches one channel, selected by setting.
// - Separate low and high thresholds and flags.
// - Below low or above high is a fault.
// - Flags set after consecutive faults reach setting.
// - Reset selects automatic range detection.
// - Automatic range re-chosen on every measurement.
// - Nine manual ranges selectable instead of automatic.
// - Range value 0xC selects automatic.
// - Twelve conversion times, 600 us to 800 ms.
// - Continuous and one-shot modes by configuration.
// - Shutdown after power-up, no conversions until programmed.
// - Threshold result drives the interrupt pin.
// - Clock line low 28 ms resets bus logic.
// - Written one-shot mode clears after measurement.
// - Trigger during conversion is ignored.
package lrit_pkg;

    localparam int CODE_W = 20;
    localparam int CNT_W = 4;
    localparam int CRC_W = 4;
    localparam logic [CRC_W-1:0] CRC_POLY = 4'h3;

    // Operating modes held in the mode register.
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_ONE_FORCE = 2'h1;
    localparam logic [1:0] MODE_ONE_REG = 2'h2;
    localparam logic [1:0] MODE_CONT = 2'h3;
    localparam logic [1:0] MODE_RST = MODE_OFF;

    // Range field: 0 to 8 manual, 0xC automatic.
    localparam logic [3:0] RANGE_AUTO = 4'hC;
    localparam logic [3:0] RANGE_MAX = 4'h8;
    localparam logic [3:0] RANGE_RST = RANGE_AUTO;
    localparam logic [3:0] CONV_SEL_LAST = 4'hB;

    // Timing, figures in nanoseconds, clock at 40 MHz.
    localparam int CLK_PERIOD_NS = 25;
    localparam int T_CONV_MIN_NS = 600000;
    localparam int T_CONV_MAX_NS = 800000000;
    localparam int T_TIMEO_NS = 28000000;
    localparam int CONV_MIN_CYC = T_CONV_MIN_NS / CLK_PERIOD_NS;
    localparam int CONV_MAX_CYC = T_CONV_MAX_NS / CLK_PERIOD_NS;
    localparam int TIMEO_CYC = T_TIMEO_NS / CLK_PERIOD_NS;
    localparam int TMR_W = 26;

    typedef enum logic [1:0] {
        ST_OFF = 2'h0,
        ST_CONV = 2'h1,
        ST_DONE = 2'h3
    } lrit_state_e;

    // One complete output record.
    typedef struct packed {
        logic [CODE_W-1:0] ch0;
        logic [CODE_W-1:0] ch1;
        logic [3:0] range;
        logic [CNT_W-1:0] count;
        logic [CRC_W-1:0] crc;
    } lrit_result_s;

    localparam int CRC_DATA_W = 2 * CODE_W + 4 + CNT_W;

endpackage : lrit_pkg

/* lrit_crc.sv */
`timescale 1ns/1ps
// Serial-equivalent CRC folded into one combinational pass.
module lrit_crc #(
    parameter int DATA_W = 48
) (
    input wire logic [DATA_W-1:0] i_data,
    output logic [lrit_pkg::CRC_W-1:0] o_crc
);

    // Most significant data bit is shifted in first.
    always_comb begin
        logic [lrit_pkg::CRC_W-1:0] c;
        c = '0;
        for (int i = DATA_W - 1; i >= 0; i--) begin
            if (c[lrit_pkg::CRC_W-1] ^ i_data[i]) begin
                c = {c[lrit_pkg::CRC_W-2:0], 1'b0} ^ lrit_pkg::CRC_POLY;
            end else begin
                c = {c[lrit_pkg::CRC_W-2:0], 1'b0};
            end
        end
        o_crc = c;
    end

endmodule : lrit_crc

/* lrit_host_model.sv */
`timescale 1ns/1ps
// Host side of the sensor: owns the bus clock pin and watches the
// pulled-up interrupt line. The bus clock stands high between frames.
module lrit_host_model (
    input wire logic i_hold_low,
    input wire logic i_int_o,
    input wire logic i_int_oe_n,
    output logic o_scl,
    output logic o_int_line
);
    // A stalled host pulls the clock low; otherwise the pull-up wins.
    assign o_scl = i_hold_low ? 1'b0 : 1'b1;
    // Released line reads high through the pull-up, so a flag reads low.
    assign o_int_line = i_int_oe_n ? 1'b1 : i_int_o;
endmodule : lrit_host_model

/* test_light_result_integrity_threshold.sv */
`timescale 1ns/1ps
// Self-checking bench for the result, counter and threshold logic.
module test_light_result_integrity_threshold;
    localparam int MIN_C = 4;
    localparam int MAX_C = 64;
    logic i_clk_sys, i_sys_rst, i_mode_wr, i_range_wr, i_scl;
    logic i_threshold_channel_select, hold_low, int_line, flo, fhi;
    logic [1:0] i_mode_val, i_fault_count, o_mode;
    logic [3:0] i_range_val, i_conv_time, o_range_cfg, o_conv_range, exp_cnt;
    logic [lrit_pkg::CODE_W-1:0] i_thr_low, i_thr_high, i_ch0_code;
    logic [lrit_pkg::CODE_W-1:0] i_ch1_code, v;
    logic o_conv_busy, o_result_valid, o_flag_low, o_flag_high;
    logic o_int_o, o_int_oe_n, o_bus_sm_rst;
    lrit_pkg::lrit_result_s o_result;
    int err_count, total_checks, run, n, r, e;

    // Short counts keep every conversion and the bus timeout brief.
    lrit_core #(.P_CONV_MIN_CYC(MIN_C), .P_CONV_MAX_CYC(MAX_C),
        .P_TIMEO_CYC(20)) dut (.i_clk_sys, .i_sys_rst, .i_mode_wr,
        .i_mode_val, .i_range_wr, .i_range_val, .i_conv_time,
        .i_threshold_channel_select, .i_thr_low, .i_thr_high,
        .i_fault_count, .i_ch0_code, .i_ch1_code, .i_scl, .o_mode,
        .o_range_cfg, .o_conv_busy, .o_conv_range, .o_result_valid,
        .o_result, .o_flag_low, .o_flag_high, .o_int_o, .o_int_oe_n,
        .o_bus_sm_rst);
    lrit_host_model host (.i_hold_low(hold_low), .i_int_o(o_int_o),
        .i_int_oe_n(o_int_oe_n), .o_scl(i_scl), .o_int_line(int_line));

    // Free-running 40 MHz system clock.
    initial begin
        i_clk_sys = 1'b0;
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end

    // Inputs change 1 ns after the edge so no race with the design.
    task automatic tick(input int k);
        repeat (k) @(posedge i_clk_sys);
        #1;
    endtask : tick

    task automatic chk(input string w, input logic [63:0] x,
        input logic [63:0] g);
        total_checks++;
        if (g !== x) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", w, x, g);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    // Serial CRC, MSB first, zero start value.
    function automatic logic [3:0] crc_of(input logic [47:0] d);
        logic [3:0] c;
        logic fb;
        c = 4'h0;
        for (int i = 47; i >= 0; i--) begin
            fb = c[3] ^ d[i];
            c = {c[2:0], 1'b0} ^ (fb ? lrit_pkg::CRC_POLY : 4'h0);
        end
        return c;
    endfunction : crc_of

    function automatic int conv_cyc(input logic [3:0] sel);
        return (sel >= 4'hB) ? MAX_C : (MIN_C << sel);
    endfunction : conv_cyc

    task automatic count_hi(input bit pick, input int cyc);
        n = 0;
        repeat (cyc) begin
            n += ((pick ? o_bus_sm_rst : o_conv_busy) === 1'b1);
            tick(1);
        end
    endtask : count_hi

    task automatic do_reset();
        i_sys_rst = 1'b1;
        tick(10);
        i_sys_rst = 1'b0;
        exp_cnt = 4'h0;
        run = 0;
        flo = 1'b0;
        fhi = 1'b0;
    endtask : do_reset

    task automatic wr_mode(input logic [1:0] m);
        i_mode_val = m;
        i_mode_wr = 1'b1;
        tick(1);
        i_mode_wr = 1'b0;
    endtask : wr_mode

    task automatic wr_range(input logic [3:0] g);
        i_range_val = g;
        i_range_wr = 1'b1;
        tick(1);
        i_range_wr = 1'b0;
    endtask : wr_range

    // Waits for one record, then checks it and the threshold flags.
    task automatic collect(input bit cb);
        logic [lrit_pkg::CODE_W-1:0] s;
        logic [3:0] c;
        int k;
        n = 0;
        for (k = 0; k < 5000 && o_result_valid !== 1'b1; k++) begin
            n += (o_conv_busy === 1'b1);
            tick(1);
        end
        if (k == 5000) begin
            err_count++;
            tally_and_finish();
        end
        exp_cnt++;
        c = crc_of({i_ch0_code, i_ch1_code, o_result.range, exp_cnt});
        if (cb) chk("busy", conv_cyc(i_conv_time), n);
        chk("ch0", i_ch0_code, o_result.ch0);
        chk("ch1", i_ch1_code, o_result.ch1);
        chk("count", exp_cnt, o_result.count);
        chk("crc", c, o_result.crc);
        s = i_threshold_channel_select ? i_ch1_code : i_ch0_code;
        if (s < i_thr_low || s > i_thr_high) begin
            run++;
            if (run > i_fault_count) begin
                flo = s < i_thr_low;
                fhi = s > i_thr_high;
            end
        end else begin
            run = 0;
            flo = 1'b0;
            fhi = 1'b0;
        end
        tick(1);
        chk("flag_low", flo, o_flag_low);
        chk("flag_high", fhi, o_flag_high);
        chk("int_line", !(flo || fhi), int_line);
    endtask : collect

    task automatic measure(input logic [1:0] m);
        wr_mode(m);
        collect(1'b1);
        chk("mode_after", 2'h0, o_mode);
    endtask : measure

    // Main sequence; thresholds start wide open so nothing faults.
    initial begin
        {i_sys_rst, i_mode_wr, i_range_wr, hold_low} = 4'h8;
        {i_mode_val, i_fault_count, i_threshold_channel_select} = 5'h00;
        {i_range_val, i_conv_time} = 8'hC0;
        {i_thr_low, i_ch0_code, i_ch1_code} = 60'h0;
        i_thr_high = 20'hFFFFF;
        err_count = 0;
        total_checks = 0;
        void'($urandom(21144));
        do_reset();
        chk("mode_rst", 2'h0, o_mode);
        chk("range_rst", lrit_pkg::RANGE_AUTO, o_range_cfg);
        chk("record_rst", 52'h0, o_result);
        chk("flags_rst", 1, {o_flag_low, o_flag_high, o_int_oe_n});
        chk("conv_range_rst", 4'h8, o_conv_range);
        count_hi(1'b0, 30);
        chk("idle_busy", 0, n);
        $display("test reset done");
        for (int i = 0; i < 20; i++) begin
            i_conv_time = (i < 2) ? 4'hA + 4'(i) : 4'($urandom_range(0, 4));
            i_ch0_code = 20'($urandom);
            i_ch1_code = 20'($urandom);
            measure(i[0] ? 2'h1 : 2'h2);
        end
        $display("test one-shot records done");
        i_conv_time = 4'h3;
        wr_mode(2'h2);
        tick(5);
        wr_mode(2'h2);
        collect(1'b0);
        count_hi(1'b0, 80);
        chk("retrigger", 0, n);
        $display("test retrigger done");
        i_conv_time = 4'h0;
        wr_range(4'h3);
        measure(2'h2);
        chk("manual_range", 4'h3, o_result.range);
        chk("conv_range", 4'h3, o_conv_range);
        wr_range(4'hE);
        measure(2'h2);
        chk("clamped_range", 4'h8, o_result.range);
        chk("conv_clamp", 4'h8, o_conv_range);
        wr_range(lrit_pkg::RANGE_AUTO);
        chk("range_cfg", lrit_pkg::RANGE_AUTO, o_range_cfg);
        {i_ch0_code, i_ch1_code} = 40'h0;
        for (int k = 0; k < 12; k++) begin
            if (k == 10) {i_ch0_code, i_ch1_code} = 40'hFFFFFFFFFF;
            measure(k == 0 ? 2'h1 : 2'h2);
            e = (k < 10) ? ((k < 8) ? 8 - k : 0) : k - 10;
            chk("auto_range", e, o_result.range);
        end
        $display("test range done");
        wr_mode(2'h3);
        repeat (3) collect(1'b1);
        chk("cont_mode", 2'h3, o_mode);
        do_reset();
        chk("mode_rst2", 2'h0, o_mode);
        chk("record_rst2", 52'h0, o_result);
        $display("test continuous done");
        hold_low = 1'b1;
        count_hi(1'b1, 12);
        chk("short_low", 0, n);
        hold_low = 1'b0;
        tick(5);
        hold_low = 1'b1;
        count_hi(1'b1, 40);
        chk("long_low", 1, n);
        hold_low = 1'b0;
        $display("test bus timeout done");
        i_thr_low = 20'h40000;
        i_thr_high = 20'hC0000;
        for (int b = 0; b < 4; b++) begin
            i_fault_count = 2'(b);
            i_threshold_channel_select = b[0];
            repeat (12) begin
                r = $urandom_range(0, 5);
                v = (r < 2) ? 20'($urandom_range(0, 20'h3FFFF)) : i_thr_high;
                if (r inside {[2:4]}) begin
                    v = 20'($urandom_range(20'hC0001, 20'hFFFFF));
                end
                i_ch0_code = b[0] ? 20'($urandom) : v;
                i_ch1_code = b[0] ? v : 20'($urandom);
                measure(2'h2);
            end
        end
        $display("test threshold done");
        tally_and_finish();
    end
endmodule : test_light_result_integrity_threshold
